// file: common/fifo_cfg_pkg.sv
// Constants, carriers and depth arithmetic shared by the FIFO design files
package fifo_cfg_pkg;

  // Default configuration
  localparam int WIDTH_DEF = 8;
  localparam int WR_DEPTH_DEF = 16;
  localparam int RD_DEPTH_DEF = 16;
  localparam int PRIM_DEPTH_MIN = 512;
  localparam int PROG_FULL_DEF = 12;
  localparam int PROG_EMPTY_DEF = 2;
  localparam int SKID_DEPTH = 2;

  // Values held during reset and at power-up
  localparam logic FULL_RST = 1'b0;
  localparam logic NEARLY_FULL_RST = 1'b0;
  localparam logic PROG_FULL_RST = 1'b0;
  localparam logic PROG_EMPTY_RST = 1'b0;
  localparam logic EMPTY_RST = 1'b1;
  localparam logic NEARLY_EMPTY_RST = 1'b1;
  localparam logic HANDSHAKE_RST = 1'b0;
  localparam logic EVENT_RST = 1'b0;

  // Flag latencies in clock edges after the operation's edge
  localparam int LAT_FLAG = 0;
  localparam int LAT_PROG = 1;

  // Memory implementation kinds
  typedef enum logic [1:0] {
    MEM_BLOCK = 2'b00,
    MEM_DIST = 2'b01,
    MEM_SHIFT = 2'b10,
    MEM_BUILTIN = 2'b11
  } mem_kind_t;

  // Write-side status carrier
  typedef struct packed {
    logic full;
    logic nearly_full;
    logic prog_full;
    logic wr_ack;
    logic overflow;
  } wr_status_t;

  // Read-side status carrier
  typedef struct packed {
    logic empty;
    logic nearly_empty;
    logic prog_empty;
    logic valid;
    logic underflow;
  } rd_status_t;

  // Error tag stored beside each word
  typedef struct packed {
    logic sbit;
    logic dbit;
  } ecc_tag_t;

  // Read depth after the width-ratio restriction
  function automatic int eff_rd_depth(int wr_d, int rd_d, mem_kind_t kind);
    eff_rd_depth = (kind == MEM_BLOCK) ? rd_d : wr_d;
  endfunction

  // Usable write depth for a configuration
  function automatic int usable_wr_depth(int wr_d, int rd_d, bit indep, bit look,
                                         mem_kind_t kind, int prim_d);
    int n;
    n = (wr_d + prim_d - 1) / prim_d;
    if (kind == MEM_BUILTIN)
      usable_wr_depth = look ? (prim_d + 1) * n : (prim_d + 1) * (n - 1) + prim_d;
    else if (!indep)
      usable_wr_depth = look ? wr_d + 2 : wr_d;
    else
      usable_wr_depth = look ? (wr_d - 1) + 2 * (wr_d / rd_d) : wr_d - 1;
  endfunction

  // Usable read depth for a configuration
  function automatic int usable_rd_depth(int rd_d, bit indep, bit look);
    if (!indep)
      usable_rd_depth = look ? rd_d + 2 : rd_d;
    else
      usable_rd_depth = look ? rd_d + 1 : rd_d - 1;
  endfunction

endpackage

// file: test/fifo_flag_asserts.sv
// Port-level checker for FIFO flags, counts and reset values
`timescale 1ns/100ps
`default_nettype none
module fifo_flag_asserts #(
  parameter int WIDTH = 8,
  parameter int CW = 5,
  parameter int PF_TH = 12,
  parameter int PE_TH = 2,
  parameter logic [WIDTH-1:0] DOUT_RST = '0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wr_rst,
  input wire logic rd_rst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [WIDTH-1:0] dout,
  input wire logic full,
  input wire logic nearly_full,
  input wire logic prog_full,
  input wire logic wr_ack,
  input wire logic overflow,
  input wire logic empty,
  input wire logic nearly_empty,
  input wire logic prog_empty,
  input wire logic valid,
  input wire logic underflow,
  input wire logic [CW-1:0] wr_data_count,
  input wire logic [CW-1:0] rd_data_count,
  input wire logic [31:0] usable_wr_depth,
  input wire logic stream_valid,
  input wire logic stream_ready,
  input wire logic [WIDTH-1:0] stream_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Either side held in reset
  logic srst;
  assign srst = wr_rst | rd_rst;
  AST_OVERFLOW: assert property (wr_en && full && !srst |=> overflow && !wr_ack)
    else $error("overflow missing");
  AST_UNDERFLOW: assert property (rd_en && empty && !srst |=> underflow && !valid)
    else $error("underflow missing");
  AST_WR_ACK: assert property (wr_en && !full && !srst |=> wr_ack && !overflow)
    else $error("write not acknowledged");
  AST_NO_WR_EVENT: assert property (!wr_en && !srst |=> !wr_ack && !overflow)
    else $error("write event without write");
  AST_WR_COUNT: assert property (wr_en && !full && !rd_en && !srst |=>
    wr_data_count == $past(wr_data_count) + 1'b1 && !empty && !valid && !underflow)
    else $error("write side effects wrong");
  AST_RST_FLAGS: assert property (wr_rst && rd_rst |=>
    {full, nearly_full, prog_full, prog_empty} == 4'h0 && empty && nearly_empty
    && wr_data_count == '0 && rd_data_count == '0)
    else $error("flags not at reset values");
  AST_RST_OUT: assert property (wr_rst && rd_rst |=> dout == DOUT_RST && !valid && !wr_ack)
    else $error("outputs not at reset values");
  AST_PROG_LAT: assert property ($past(rst_b) && !$past(srst) |->
    prog_full == ($past(wr_data_count) >= PF_TH)
    && prog_empty == ($past(rd_data_count) <= PE_TH))
    else $error("threshold flag latency wrong");
  AST_ZERO_LAT: assert property (empty == (rd_data_count == '0)
    && full == (wr_data_count == usable_wr_depth[CW-1:0]))
    else $error("flag and count disagree");
  AST_STREAM_HOLD: assert property (stream_valid && !stream_ready && !srst |=>
    stream_valid && $stable(stream_data))
    else $error("stalled word lost");
endmodule
bind fifo_sync_reset_depth_latency fifo_flag_asserts #(.WIDTH(WIDTH), .CW(CW),
  .PF_TH(PROG_FULL_TH), .PE_TH(PROG_EMPTY_TH), .DOUT_RST(DOUT_RST)) fifo_flag_asserts_inst (
  .clk(clk), .rst_b(rst_b), .wr_rst(wr_rst), .rd_rst(rd_rst), .wr_en(wr_en), .rd_en(rd_en),
  .dout(dout), .full(full), .nearly_full(nearly_full), .prog_full(prog_full),
  .wr_ack(wr_ack), .overflow(overflow), .empty(empty), .nearly_empty(nearly_empty),
  .prog_empty(prog_empty), .valid(valid), .underflow(underflow),
  .wr_data_count(wr_data_count), .rd_data_count(rd_data_count),
  .usable_wr_depth(usable_wr_depth), .stream_valid(stream_valid),
  .stream_ready(stream_ready), .stream_data(stream_data));
`default_nettype wire

// file: test/stream_sink.sv
// Receiver model for the stream port, prompt or paced, with a stall input
`timescale 1ns/100ps
`default_nettype none
module stream_sink #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic stall,
  input wire logic slow,
  input wire logic stream_valid,
  output logic stream_ready,
  input wire logic [W-1:0] stream_data
);
  logic pace_reg;
  logic [W-1:0] got[$];
  // Ready unless stalled; every other cycle when paced
  assign stream_ready = !stall && (!slow || pace_reg);
  // Keep each word taken at a handshake edge
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      pace_reg <= 1'b0;
    else
    begin
      pace_reg <= !pace_reg;
      if (stream_valid && stream_ready)
        got.push_back(stream_data);
    end
  end
endmodule
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench: reset values, fill, overflow, stalled drain, sync reset
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, sg) \
  begin n_checks++; if ((sg) !== (ex)) begin n_mismatch++; \
  $display("ERROR %s expected %h seen %h", nm, ex, sg); end end
module tb_top;
  localparam int CW = 5;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wr_rst = 1'b0;
  logic rd_rst = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] din = 8'h00;
  logic stall = 1'b1;
  logic slow = 1'b0;
  logic inj = 1'b0;
  logic sbit_err, dbit_err;
  logic [7:0] dout, stream_data;
  logic full, nearly_full, prog_full, wr_ack, overflow, empty, nearly_empty;
  logic prog_empty, valid, underflow, stream_valid, stream_ready;
  logic [CW-1:0] wr_data_count, rd_data_count;
  logic [31:0] usable_wr_depth, usable_rd_depth;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;

  fifo_sync_reset_depth_latency #(.DOUT_RST(8'h5a)) fifo_sync_reset_depth_latency_inst (
    .clk(clk), .rst_b(rst_b), .wr_rst(wr_rst), .rd_rst(rd_rst), .wr_en(wr_en), .din(din),
    .wr_sbit_inj(inj), .wr_dbit_inj(1'b0), .rd_en(rd_en), .dout(dout), .full(full),
    .nearly_full(nearly_full), .prog_full(prog_full), .wr_ack(wr_ack),
    .overflow(overflow), .empty(empty), .nearly_empty(nearly_empty),
    .prog_empty(prog_empty), .valid(valid), .underflow(underflow), .sbit_err(sbit_err),
    .dbit_err(dbit_err), .wr_data_count(wr_data_count), .rd_data_count(rd_data_count),
    .usable_wr_depth(usable_wr_depth), .usable_rd_depth(usable_rd_depth),
    .stream_valid(stream_valid), .stream_ready(stream_ready), .stream_data(stream_data));

  stream_sink #(.W(8)) stream_sink_inst (
    .clk(clk), .rst_b(rst_b), .stall(stall), .slow(slow), .stream_valid(stream_valid),
    .stream_ready(stream_ready), .stream_data(stream_data));

  // Free-running clock
  initial
  begin
    forever #5 clk = ~clk;
  end

  // Prints counts and verdict, then ends the run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end

  // One cycle of user requests, applied at the falling edge
  task automatic step(input logic we, input logic [7:0] d, input logic re);
    wr_en = we;
    din = d;
    rd_en = re;
    @(negedge clk);
  endtask

  // Outputs while held in reset, then first edge after release
  task automatic t_reset();
    `CHK("dout", 8'h5a, dout)
    `CHK("wr flags", 3'b000, {full, nearly_full, prog_full})
    `CHK("rd flags", 3'b110, {empty, nearly_empty, prog_empty})
    `CHK("counts", 10'h000, {wr_data_count, rd_data_count})
    `CHK("handshake", 2'b00, {valid, wr_ack})
    `CHK("err tags", 2'b00, {sbit_err, dbit_err})
    `CHK("depths", 64'h00000010_00000010, {usable_wr_depth, usable_rd_depth})
    rst_b = 1'b1;
    @(negedge clk);
    `CHK("prog_empty", 1'b1, prog_empty)
  endtask

  // Back-to-back writes up to full, then one refused write
  task automatic t_fill();
    for (int i = 0; i < 16; i++)
    begin
      step(1'b1, 8'h10 + 8'(i), 1'b0);
      `CHK("wr_ack", 1'b1, wr_ack)
      `CHK("wr count", 5'(i + 1), wr_data_count)
      `CHK("full pair", {i == 15, i >= 14}, {full, nearly_full})
      `CHK("prog_full", i >= 12, prog_full)
      `CHK("empty", 1'b0, empty)
    end
    step(1'b1, 8'hff, 1'b0);
    `CHK("overflow", 2'b10, {overflow, wr_ack})
    step(1'b0, 8'h00, 1'b0);
    `CHK("overflow pulse", 1'b0, overflow)
  endtask

  // Reads into a stalled receiver until refused, then paced drain and underflow
  task automatic t_drain();
    int n;
    step(1'b0, 8'h00, 1'b1);
    `CHK("read word", 10'h210, {valid, full, dout})
    `CHK("rd count", 5'h0f, rd_data_count)
    step(1'b0, 8'h00, 1'b1);
    `CHK("read word", 9'h111, {valid, dout})
    step(1'b0, 8'h00, 1'b1);
    `CHK("refused read", 6'h0e, {valid, rd_data_count})
    stall = 1'b0;
    slow = 1'b1;
    n = 0;
    while (rd_data_count !== 5'h00 && n < 200)
    begin
      step(1'b0, 8'h00, 1'b1);
      n++;
    end
    step(1'b0, 8'h00, 1'b1);
    `CHK("underflow", 2'b10, {underflow, valid})
    repeat (6) step(1'b0, 8'h00, 1'b0);
    `CHK("underflow pulse", 1'b0, underflow)
    `CHK("words seen", 16, stream_sink_inst.got.size())
    for (int i = 0; i < 16; i++)
      `CHK("word order", 8'h10 + 8'(i), stream_sink_inst.got[i])
  endtask

  // One-cycle reset of both sides, then immediate traffic
  task automatic t_sync_reset();
    step(1'b1, 8'h21, 1'b0);
    step(1'b1, 8'h22, 1'b0);
    step(1'b0, 8'h00, 1'b1);
    `CHK("dout before reset", 8'h21, dout)
    wr_rst = 1'b1;
    rd_rst = 1'b1;
    step(1'b0, 8'h00, 1'b0);
    wr_rst = 1'b0;
    rd_rst = 1'b0;
    `CHK("dout reset", 8'h5a, dout)
    `CHK("reset flags", 6'h06, {full, nearly_full, prog_full, empty, nearly_empty, prog_empty})
    `CHK("reset counts", 12'h000, {wr_data_count, rd_data_count, valid, wr_ack})
    inj = 1'b1;
    step(1'b1, 8'ha5, 1'b0);
    inj = 1'b0;
    `CHK("first write", 7'h41, {wr_ack, empty, wr_data_count})
    step(1'b0, 8'h00, 1'b1);
    `CHK("first read", 9'h1a5, {valid, dout})
    `CHK("err tag", 2'b10, {sbit_err, dbit_err})
    step(1'b0, 8'h00, 1'b0);
  endtask

  // Main sequence
  initial
  begin
    repeat (8) @(negedge clk);
    t_reset();
    t_fill();
    t_drain();
    t_sync_reset();
    give_verdict();
  end
endmodule
`default_nettype wire

// file: verilog/fifo_sync_reset_depth_latency.sv
// Memory FIFO with per-side synchronous resets, depth arithmetic and zero-latency flags
//
// Summary of operation
// - Each side's reset clears that side's counters and outputs on its own edge.
// - Lookahead error indications may stay high until the first valid read.
// - One clock cycle of synchronous reset fully resets the FIFO.
// - Reads and writes are accepted on the cycle right after reset release.
// - Read word shows configured reset value, else zero, in reset and power-up.
// - Underflow asserts when read enable arrives while empty.
// - Overflow asserts when write enable arrives while full.
// - Reset: full, nearly-full, prog flags zero; empty, nearly-empty one; counts zero.
// - Reset: read-valid and write-acknowledge inactive at their configured polarity.
// - Common-clock lookahead FIFO gives two extra usable entries.
// - Independent-clock standard FIFO gives one entry less than configured.
// - Independent lookahead: write depth minus one plus twice ratio; read plus one.
// - Unequal port depths exist only in block memory implementations.
// - Cascaded primitive depth formulas, primitive depth at least 512.
// - Latency zero means the flag changes on the operation's own edge.
// - Write updates full, nearly-full, ack, overflow at once; prog full one later.
// - Read updates empty, nearly-empty, valid, underflow, count at once; prog empty later.
// - Read updates full flags at once, prog full later, never ack or overflow.
// - Write updates empty flags and count at once, never underflow; it sets valid only in lookahead mode.
// - Common-clock reset clears counters, outputs and memory without synchronisers.
`timescale 1ns/100ps
`default_nettype none

module fifo_sync_reset_depth_latency #(
  parameter int WIDTH = fifo_cfg_pkg::WIDTH_DEF,
  parameter int WR_DEPTH = fifo_cfg_pkg::WR_DEPTH_DEF,
  parameter int RD_DEPTH = fifo_cfg_pkg::RD_DEPTH_DEF,
  parameter bit INDEP_CLK = 1'b0,
  parameter bit LOOKAHEAD = 1'b0,
  parameter fifo_cfg_pkg::mem_kind_t MEM_KIND = fifo_cfg_pkg::MEM_BLOCK,
  parameter int PRIM_DEPTH = fifo_cfg_pkg::PRIM_DEPTH_MIN,
  parameter logic [WIDTH-1:0] DOUT_RST = '0,
  parameter bit VALID_LOW = 1'b0,
  parameter bit ACK_LOW = 1'b0,
  parameter int PROG_FULL_TH = fifo_cfg_pkg::PROG_FULL_DEF,
  parameter int PROG_EMPTY_TH = fifo_cfg_pkg::PROG_EMPTY_DEF,
  // Derived sizes
  parameter int DEPTH = fifo_cfg_pkg::usable_wr_depth(WR_DEPTH,
    fifo_cfg_pkg::eff_rd_depth(WR_DEPTH, RD_DEPTH, MEM_KIND), INDEP_CLK, LOOKAHEAD,
    MEM_KIND, (PRIM_DEPTH < fifo_cfg_pkg::PRIM_DEPTH_MIN) ? fifo_cfg_pkg::PRIM_DEPTH_MIN
    : PRIM_DEPTH),
  parameter int RDEPTH = fifo_cfg_pkg::usable_rd_depth(
    fifo_cfg_pkg::eff_rd_depth(WR_DEPTH, RD_DEPTH, MEM_KIND), INDEP_CLK, LOOKAHEAD),
  parameter int CW = $clog2(DEPTH + 1),
  parameter int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wr_rst,
  input wire logic rd_rst,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] din,
  input wire logic wr_sbit_inj,
  input wire logic wr_dbit_inj,
  input wire logic rd_en,
  output logic [WIDTH-1:0] dout,
  output logic full,
  output logic nearly_full,
  output logic prog_full,
  output logic wr_ack,
  output logic overflow,
  output logic empty,
  output logic nearly_empty,
  output logic prog_empty,
  output logic valid,
  output logic underflow,
  output logic sbit_err,
  output logic dbit_err,
  output logic [CW-1:0] wr_data_count,
  output logic [CW-1:0] rd_data_count,
  output logic [31:0] usable_wr_depth,
  output logic [31:0] usable_rd_depth,
  output logic stream_valid,
  input wire logic stream_ready,
  output logic [WIDTH-1:0] stream_data
);

  // Pointer step that wraps at a depth that need not be a power of two
  function automatic logic [AW-1:0] ptr_inc(logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  logic [WIDTH-1:0] mem [DEPTH];
  fifo_cfg_pkg::ecc_tag_t tag_mem [DEPTH];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  fifo_cfg_pkg::wr_status_t ws_reg, ws_next;
  fifo_cfg_pkg::rd_status_t rs_reg, rs_next;
  logic [WIDTH-1:0] dout_reg, dout_next;
  fifo_cfg_pkg::ecc_tag_t err_reg, err_next;
  logic wr_go, rd_go, any_rst, buf_ready, buf_push;
  logic [1:0] buf_level;
  logic room;

  // Reported usable depths
  assign usable_wr_depth = 32'(DEPTH);
  assign usable_rd_depth = 32'(RDEPTH);

  // Outputs straight from flops; polarity constants fold in
  assign dout = dout_reg;
  assign full = ws_reg.full;
  assign nearly_full = ws_reg.nearly_full;
  assign prog_full = ws_reg.prog_full;
  assign wr_ack = ws_reg.wr_ack ^ ACK_LOW;
  assign overflow = ws_reg.overflow;
  assign empty = rs_reg.empty;
  assign nearly_empty = rs_reg.nearly_empty;
  assign prog_empty = rs_reg.prog_empty;
  assign valid = rs_reg.valid ^ VALID_LOW;
  assign underflow = rs_reg.underflow;
  assign sbit_err = err_reg.sbit;
  assign dbit_err = err_reg.dbit;
  assign wr_data_count = cnt_reg;
  assign rd_data_count = cnt_reg;

  // Room in the output buffer, counting a standard-mode word still in flight
  assign room = LOOKAHEAD ? buf_ready :
    ((buf_level == 2'h0) || ((buf_level == 2'h1) && !rs_reg.valid));
  assign any_rst = wr_rst | rd_rst;

  // Accepted operations; nothing waits after reset release
  assign wr_go = wr_en & ~ws_reg.full & ~wr_rst;
  assign rd_go = rd_en & ~rs_reg.empty & room & ~rd_rst;
  assign buf_push = LOOKAHEAD ? rd_go : rs_reg.valid;

  // Pointers and occupancy
  always_comb
  begin
    wp_next = wr_go ? ptr_inc(wp_reg) : wp_reg;
    rp_next = rd_go ? ptr_inc(rp_reg) : rp_reg;
    cnt_next = cnt_reg + CW'(wr_go) - CW'(rd_go);
    if (wr_rst)
      wp_next = '0;
    if (rd_rst)
      rp_next = '0;
    if (any_rst)
      cnt_next = '0;
  end

  // Write-side flags
  always_comb
  begin
    ws_next.full = (cnt_next == CW'(DEPTH));
    ws_next.nearly_full = (cnt_next >= CW'(DEPTH - 1));
    ws_next.prog_full = (cnt_reg >= CW'(PROG_FULL_TH));
    ws_next.wr_ack = wr_go;
    ws_next.overflow = wr_en & ws_reg.full;
    if (wr_rst)
    begin
      ws_next.full = fifo_cfg_pkg::FULL_RST;
      ws_next.nearly_full = fifo_cfg_pkg::NEARLY_FULL_RST;
      ws_next.prog_full = fifo_cfg_pkg::PROG_FULL_RST;
      ws_next.wr_ack = fifo_cfg_pkg::HANDSHAKE_RST;
      ws_next.overflow = fifo_cfg_pkg::EVENT_RST;
    end
  end

  // Read-side flags, read word and error tags
  always_comb
  begin
    rs_next.empty = (cnt_next == '0);
    rs_next.nearly_empty = (cnt_next <= CW'(1));
    rs_next.prog_empty = (cnt_reg <= CW'(PROG_EMPTY_TH));
    rs_next.underflow = rd_en & rs_reg.empty;
    dout_next = dout_reg;
    err_next = err_reg;
    if (LOOKAHEAD)
    begin
      // Head word is shown before it is taken; a head being written now bypasses memory
      rs_next.valid = (cnt_next != '0);
      if (wr_go && (rp_next == wp_reg))
      begin
        dout_next = din;
        err_next = '{sbit: wr_sbit_inj, dbit: wr_dbit_inj};
      end
      else if (cnt_next != '0)
      begin
        dout_next = mem[rp_next];
        err_next = tag_mem[rp_next];
      end
    end
    else
    begin
      rs_next.valid = rd_go;
      if (rd_go)
      begin
        dout_next = mem[rp_reg];
        err_next = tag_mem[rp_reg];
      end
    end
    if (rd_rst)
    begin
      rs_next.empty = fifo_cfg_pkg::EMPTY_RST;
      rs_next.nearly_empty = fifo_cfg_pkg::NEARLY_EMPTY_RST;
      rs_next.prog_empty = fifo_cfg_pkg::PROG_EMPTY_RST;
      rs_next.valid = fifo_cfg_pkg::HANDSHAKE_RST;
      rs_next.underflow = fifo_cfg_pkg::EVENT_RST;
      dout_next = DOUT_RST;
      err_next = '0;
    end
  end

  // Flag and pointer registers; power-up equals reset state
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      ws_reg <= '{full: fifo_cfg_pkg::FULL_RST, nearly_full: fifo_cfg_pkg::NEARLY_FULL_RST,
                 prog_full: fifo_cfg_pkg::PROG_FULL_RST, wr_ack: fifo_cfg_pkg::HANDSHAKE_RST,
                 overflow: fifo_cfg_pkg::EVENT_RST};
      rs_reg <= '{empty: fifo_cfg_pkg::EMPTY_RST, nearly_empty: fifo_cfg_pkg::NEARLY_EMPTY_RST,
                 prog_empty: fifo_cfg_pkg::PROG_EMPTY_RST, valid: fifo_cfg_pkg::HANDSHAKE_RST,
                 underflow: fifo_cfg_pkg::EVENT_RST};
      dout_reg <= DOUT_RST;
      err_reg <= '0;
    end
    else
    begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
      ws_reg <= ws_next;
      rs_reg <= rs_next;
      dout_reg <= dout_next;
      err_reg <= err_next;
    end
  end

  // Storage; a common-clock reset also wipes the contents
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mem <= '{default: '0};
      tag_mem <= '{default: '0};
    end
    else if (!INDEP_CLK && any_rst)
    begin
      mem <= '{default: '0};
      tag_mem <= '{default: '0};
    end
    else if (wr_go)
    begin
      mem[wp_reg] <= din;
      tag_mem[wp_reg] <= '{sbit: wr_sbit_inj, dbit: wr_dbit_inj};
    end
  end

  // Output stream buffer; a full buffer holds back reads
  skid_buffer2 #(
    .W(WIDTH)
  ) u_skid (
    .clk(clk),
    .rst_b(rst_b),
    .clr(rd_rst),
    .in_valid(buf_push),
    .in_ready(buf_ready),
    .in_data(dout_reg),
    .out_valid(stream_valid),
    .out_ready(stream_ready),
    .out_data(stream_data),
    .level(buf_level)
  );

endmodule
`default_nettype wire

// file: verilog/skid_buffer2.sv
// Two-entry valid/ready buffer on the read word path
`timescale 1ns/100ps
`default_nettype none

module skid_buffer2 #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clr,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [1:0] level
);

  logic [W-1:0] slot_reg [fifo_cfg_pkg::SKID_DEPTH];
  logic [W-1:0] slot_next [fifo_cfg_pkg::SKID_DEPTH];
  logic wp_reg, wp_next, rp_reg, rp_next;
  logic [1:0] level_reg, level_next;
  logic push, pop;

  // Handshakes and occupancy
  assign in_ready = (level_reg != 2'(fifo_cfg_pkg::SKID_DEPTH));
  assign out_valid = (level_reg != 2'h0);
  assign out_data = slot_reg[rp_reg];
  assign level = level_reg;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Next pointers, level and slots
  always_comb
  begin
    slot_next = slot_reg;
    wp_next = wp_reg;
    rp_next = rp_reg;
    level_next = level_reg;
    if (clr)
    begin
      wp_next = 1'b0;
      rp_next = 1'b0;
      level_next = 2'h0;
    end
    else
    begin
      if (push)
      begin
        slot_next[wp_reg] = in_data;
        wp_next = ~wp_reg;
      end
      if (pop)
        rp_next = ~rp_reg;
      level_next = level_reg + 2'(push) - 2'(pop);
    end
  end

  // State registers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      slot_reg <= '{default: '0};
      wp_reg <= 1'b0;
      rp_reg <= 1'b0;
      level_reg <= 2'h0;
    end
    else
    begin
      slot_reg <= slot_next;
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      level_reg <= level_next;
    end
  end

endmodule
`default_nettype wire
